// file: hdl/lamcfg_regs.svh
// register indexes, field positions, reset values for the alias/mailbox/pin bank
// assumes: byte address on the bus is four times the register index
`ifndef LAMCFG_REGS_SVH
`define LAMCFG_REGS_SVH

// ==========================================
// register indexes
`define LAMCFG_IDX_ALIAS7 8'h17
`define LAMCFG_IDX_MSG_A 8'h18
`define LAMCFG_IDX_MSG_B 8'h19
`define LAMCFG_IDX_PINCFG 8'h1a
`define LAMCFG_IDX_TGTID7 8'h20
`define LAMCFG_IDX_RMTCTL 8'h21
`define LAMCFG_IDX_STATUS 8'h22

// ==========================================
// reset values
`define LAMCFG_RST_ALIAS7 8'h00
`define LAMCFG_RST_MSG_A 8'h00
`define LAMCFG_RST_MSG_B 8'h01
`define LAMCFG_RST_PINCFG 8'h00
`define LAMCFG_RST_TGTID7 8'h00
`define LAMCFG_RST_RMTCTL 8'h00

// ==========================================
// field positions
`define LAMCFG_ALIAS_MSB 7
`define LAMCFG_ALIAS_LSB 1
`define LAMCFG_GLB_LEVEL 7
`define LAMCFG_GLB_DIR 5
`define LAMCFG_GLB_EN 4
`define LAMCFG_P9_LEVEL 3
`define LAMCFG_P9_DIR 1
`define LAMCFG_P9_EN 0
`define LAMCFG_RMT_EN 0
`define LAMCFG_PINCFG_MASK 8'hbb
`define LAMCFG_ALIAS_MASK 8'hfe
`define LAMCFG_RMTCTL_MASK 8'h01

`endif

// file: hdl/lamcfg_pkg.sv
// types shared by the alias/mailbox/pin bank
// assumes: nothing beyond the standard language
package lamcfg_pkg;

    // ==========================================
    // pin mode from a {dir, en} pair
    typedef enum logic [1:0] {
        LAMCFG_FUNC_OUT = 2'b00,
        LAMCFG_GP_OUT = 2'b01,
        LAMCFG_TRI = 2'b10,
        LAMCFG_GP_IN = 2'b11
    } lamcfg_mode_t;

endpackage

// file: hdl/lamcfg_pin_if.sv
// carrier between the bank and one pin selector
// assumes: one instance per general-purpose pin
`timescale 1ns/10ps
`default_nettype none

interface lamcfg_pin_if;
    logic [1:0] pin_cfg;
    logic [1:0] glob_cfg;
    logic glob_level;
    logic level;
    logic remote_en;
    logic remote_level;
    logic func_out;
    logic drive;
    logic oe;

    modport sel
    (
        input pin_cfg, glob_cfg, glob_level, level, remote_en, remote_level, func_out,
        output drive, oe
    );
    modport ctl
    (
        output pin_cfg, glob_cfg, glob_level, level, remote_en, remote_level, func_out,
        input drive, oe
    );
endinterface

`default_nettype wire

// file: hdl/lamcfg_pin_sel.sv
// per-pin drive selection from per-pin and global settings
// assumes: outputs are registered by the instantiating bank
`timescale 1ns/10ps
`default_nettype none

module lamcfg_pin_sel
(
    lamcfg_pin_if.sel p
);

    lamcfg_pkg::lamcfg_mode_t pin_mode;
    lamcfg_pkg::lamcfg_mode_t glob_mode;

    assign pin_mode = lamcfg_pkg::lamcfg_mode_t'(p.pin_cfg);
    assign glob_mode = lamcfg_pkg::lamcfg_mode_t'(p.glob_cfg);

    // ==========================================
    // selection
    always_comb
    begin
        p.drive = 1'b0;
        p.oe = 1'b0;
        // per-pin setting wins unless it is left functional
        case (pin_mode) // [RULE8]
            lamcfg_pkg::LAMCFG_GP_OUT:
            begin
                p.oe = 1'b1;
                p.drive = p.remote_en ? p.remote_level : p.level; // [RULE9]
            end
            lamcfg_pkg::LAMCFG_TRI:
            begin
                p.oe = 1'b0;
            end
            lamcfg_pkg::LAMCFG_GP_IN:
            begin
                p.oe = 1'b0;
            end
            lamcfg_pkg::LAMCFG_FUNC_OUT:
            begin
                case (glob_mode) // [RULE7]
                    lamcfg_pkg::LAMCFG_FUNC_OUT:
                    begin
                        p.oe = 1'b1;
                        p.drive = p.func_out;
                    end
                    lamcfg_pkg::LAMCFG_GP_OUT:
                    begin
                        p.oe = 1'b1;
                        p.drive = p.glob_level; // [RULE5]
                    end
                    default:
                    begin
                        p.oe = 1'b0;
                    end
                endcase
            end
            default:
            begin
                p.oe = 1'b0;
            end
        endcase
    end

endmodule

`default_nettype wire

// file: hdl/lamcfg_bank.sv
// alias decoder, mailboxes and pin configuration bank behind an apb slave
// assumes: apb master on pclk; i2c address strobe and pin inputs synchronous to pclk
//
// Operation
// [RULE1] incoming address matching alias bits 7..1 targets the remote side
// [RULE2] matched address forwarded, replaced by the paired target id
// [RULE3] alias zero disables the decoder entirely
// [RULE4] two 8-bit mailboxes store and return values, no side effects
// [RULE5] global level drives unconfigured pins when global mode is forced output
// [RULE6] global mode is formed from direction bit 5 and enable bit 4
// [RULE7] global decode: 00 functional, 10 tri-state, 01 forced out, 11 forced in
// [RULE8] per-pin settings override the global settings
// [RULE9] pin 9 level driven when gp output and remote control off
// [RULE10] pin 9 mode formed from direction bit 1 and enable bit 0
// [RULE11] pin 9 decode: 00 functional, 10 tri-state, 01 gp out, 11 gp in
// [RULE12] reserved bits read zero and ignore writes
//
// Chosen here: the APB register port.
`timescale 1ns/10ps
`default_nettype none
`include "lamcfg_regs.svh"

module lamcfg_bank
#(
    parameter int NUM_GP = 3
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic i2c_addr_valid,
    input wire logic [6:0] i2c_addr,
    output logic fwd_valid,
    output logic [6:0] fwd_addr,
    input wire logic pin9_in,
    input wire logic pin9_func_out,
    input wire logic pin9_remote_level,
    output logic pin9_out,
    output logic pin9_oe,
    input wire logic [NUM_GP-1:0] gp_in,
    input wire logic [2*NUM_GP-1:0] gp_cfg,
    input wire logic [NUM_GP-1:0] gp_level,
    input wire logic [NUM_GP-1:0] gp_func_out,
    output logic [NUM_GP-1:0] gp_out,
    output logic [NUM_GP-1:0] gp_oe
);

    // ==========================================
    // registers
    logic [7:0] alias7_r;
    logic [7:0] msg_a_r;
    logic [7:0] msg_b_r;
    logic [7:0] pincfg_r;
    logic [7:0] tgtid7_r;
    logic [7:0] rmtctl_r;
    logic pin9_in_r;
    logic [NUM_GP-1:0] gp_in_r;
    logic hit_last_r;
    logic [7:0] hit_cnt_r;
    logic [31:0] prdata_r;
    logic pready_r;
    logic pslverr_r;
    logic fwd_valid_r;
    logic [6:0] fwd_addr_r;
    logic pin9_out_r;
    logic pin9_oe_r;
    logic [NUM_GP-1:0] gp_out_r;
    logic [NUM_GP-1:0] gp_oe_r;

    // ==========================================
    // bus decode
    logic [7:0] idx;
    logic in_range;
    logic setup_ph;
    logic wr_take;
    logic low_lane;
    logic hit_alias7;
    logic hit_msg_a;
    logic hit_msg_b;
    logic hit_pincfg;
    logic hit_tgtid7;
    logic hit_rmtctl;
    logic hit_status;
    logic mapped;
    logic [7:0] wbyte;
    logic [31:0] rd_nxt;

    assign idx = paddr[9:2];
    assign in_range = (paddr[11:10] == 2'b00) && (paddr[1:0] == 2'b00);
    assign setup_ph = psel && !penable;
    assign wr_take = psel && penable && pready_r && pwrite && !pslverr_r;
    assign low_lane = pstrb[0];
    assign wbyte = pwdata[7:0];
    assign hit_alias7 = in_range && (idx == `LAMCFG_IDX_ALIAS7);
    assign hit_msg_a = in_range && (idx == `LAMCFG_IDX_MSG_A);
    assign hit_msg_b = in_range && (idx == `LAMCFG_IDX_MSG_B);
    assign hit_pincfg = in_range && (idx == `LAMCFG_IDX_PINCFG);
    assign hit_tgtid7 = in_range && (idx == `LAMCFG_IDX_TGTID7);
    assign hit_rmtctl = in_range && (idx == `LAMCFG_IDX_RMTCTL);
    assign hit_status = in_range && (idx == `LAMCFG_IDX_STATUS);
    assign mapped = hit_alias7 || hit_msg_a || hit_msg_b || hit_pincfg
        || hit_tgtid7 || hit_rmtctl || hit_status;

    always_comb
    begin
        rd_nxt = 32'h0000_0000;
        if (hit_alias7)
        begin
            rd_nxt[7:0] = alias7_r & `LAMCFG_ALIAS_MASK; // [RULE12]
        end
        else if (hit_msg_a)
        begin
            rd_nxt[7:0] = msg_a_r; // [RULE4]
        end
        else if (hit_msg_b)
        begin
            rd_nxt[7:0] = msg_b_r; // [RULE4]
        end
        else if (hit_pincfg)
        begin
            rd_nxt[7:0] = pincfg_r & `LAMCFG_PINCFG_MASK; // [RULE12]
        end
        else if (hit_tgtid7)
        begin
            rd_nxt[7:0] = tgtid7_r & `LAMCFG_ALIAS_MASK; // [RULE12]
        end
        else if (hit_rmtctl)
        begin
            rd_nxt[7:0] = rmtctl_r & `LAMCFG_RMTCTL_MASK; // [RULE12]
        end
        else if (hit_status)
        begin
            rd_nxt[0] = pin9_in_r;
            rd_nxt[1] = hit_last_r;
            rd_nxt[15:8] = hit_cnt_r;
            rd_nxt[16 +: NUM_GP] = gp_in_r;
        end
    end

    // ==========================================
    // apb handshake: answer prepared in setup, ready in access
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
        end
        else if (setup_ph)
        begin
            pready_r <= 1'b1;
            pslverr_r <= !mapped || (pwrite && hit_status);
            prdata_r <= (pwrite || !mapped) ? 32'h0000_0000 : rd_nxt;
        end
        else
        begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end
    end

    // ==========================================
    // alias and target id
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            alias7_r <= `LAMCFG_RST_ALIAS7;
            tgtid7_r <= `LAMCFG_RST_TGTID7;
        end
        else if (wr_take && low_lane)
        begin
            if (hit_alias7)
            begin
                alias7_r <= wbyte & `LAMCFG_ALIAS_MASK; // [RULE12]
            end
            if (hit_tgtid7)
            begin
                tgtid7_r <= wbyte & `LAMCFG_ALIAS_MASK;
            end
        end
    end

    // ==========================================
    // mailboxes
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            msg_a_r <= `LAMCFG_RST_MSG_A;
            msg_b_r <= `LAMCFG_RST_MSG_B;
        end
        else if (wr_take && low_lane)
        begin
            if (hit_msg_a)
            begin
                msg_a_r <= wbyte; // [RULE4]
            end
            if (hit_msg_b)
            begin
                msg_b_r <= wbyte; // [RULE4]
            end
        end
    end

    // ==========================================
    // pin configuration and remote control
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pincfg_r <= `LAMCFG_RST_PINCFG;
            rmtctl_r <= `LAMCFG_RST_RMTCTL;
        end
        else if (wr_take && low_lane)
        begin
            if (hit_pincfg)
            begin
                pincfg_r <= wbyte & `LAMCFG_PINCFG_MASK; // [RULE12]
            end
            if (hit_rmtctl)
            begin
                rmtctl_r <= wbyte & `LAMCFG_RMTCTL_MASK;
            end
        end
    end

    // ==========================================
    // alias decoder
    logic [6:0] remote_alias_seven;
    logic alias_match;

    assign remote_alias_seven = alias7_r[`LAMCFG_ALIAS_MSB:`LAMCFG_ALIAS_LSB];
    // zero alias never matches
    assign alias_match = (remote_alias_seven != 7'h00) // [RULE3]
        && (i2c_addr == remote_alias_seven); // [RULE1]

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            fwd_valid_r <= 1'b0;
            fwd_addr_r <= 7'h00;
        end
        else
        begin
            fwd_valid_r <= i2c_addr_valid && alias_match; // [RULE1]
            if (i2c_addr_valid && alias_match)
            begin
                fwd_addr_r <= tgtid7_r[`LAMCFG_ALIAS_MSB:`LAMCFG_ALIAS_LSB]; // [RULE2]
            end
        end
    end

    // lookup status, count saturates
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            hit_last_r <= 1'b0;
            hit_cnt_r <= 8'h00;
        end
        else if (i2c_addr_valid)
        begin
            hit_last_r <= alias_match;
            if (alias_match && (hit_cnt_r != 8'hff))
            begin
                hit_cnt_r <= hit_cnt_r + 8'h01;
            end
        end
    end

    // ==========================================
    // pin selection
    logic [1:0] glob_cfg;
    logic [1:0] pin9_cfg;
    logic pin9_out_level;
    logic pin9_dir_bit;
    logic pin9_en_bit;

    assign glob_cfg = {pincfg_r[`LAMCFG_GLB_DIR], pincfg_r[`LAMCFG_GLB_EN]}; // [RULE6]
    assign pin9_dir_bit = pincfg_r[`LAMCFG_P9_DIR];
    assign pin9_en_bit = pincfg_r[`LAMCFG_P9_EN];
    assign pin9_out_level = pincfg_r[`LAMCFG_P9_LEVEL];
    assign pin9_cfg = {pin9_dir_bit, pin9_en_bit}; // [RULE10]

    lamcfg_pin_if p9_if ();

    assign p9_if.pin_cfg = pin9_cfg; // [RULE11]
    assign p9_if.glob_cfg = glob_cfg;
    assign p9_if.glob_level = pincfg_r[`LAMCFG_GLB_LEVEL];
    assign p9_if.level = pin9_out_level;
    assign p9_if.remote_en = rmtctl_r[`LAMCFG_RMT_EN];
    assign p9_if.remote_level = pin9_remote_level;
    assign p9_if.func_out = pin9_func_out;

    lamcfg_pin_sel u_p9_sel
    (
        .p(p9_if.sel)
    );

    logic [NUM_GP-1:0] gp_drive;
    logic [NUM_GP-1:0] gp_en;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_GP; gi = gi + 1)
        begin : g_gp
            lamcfg_pin_if gp_if ();

            assign gp_if.pin_cfg = gp_cfg[2*gi +: 2];
            assign gp_if.glob_cfg = glob_cfg; // [RULE6]
            assign gp_if.glob_level = pincfg_r[`LAMCFG_GLB_LEVEL];
            assign gp_if.level = gp_level[gi];
            assign gp_if.remote_en = 1'b0;
            assign gp_if.remote_level = 1'b0;
            assign gp_if.func_out = gp_func_out[gi];
            assign gp_drive[gi] = gp_if.drive;
            assign gp_en[gi] = gp_if.oe;

            lamcfg_pin_sel u_sel
            (
                .p(gp_if.sel)
            );
        end
    endgenerate

    // registered pin outputs and sampled inputs
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pin9_out_r <= 1'b0;
            pin9_oe_r <= 1'b0;
            gp_out_r <= '0;
            gp_oe_r <= '0;
            pin9_in_r <= 1'b0;
            gp_in_r <= '0;
        end
        else
        begin
            pin9_out_r <= p9_if.drive;
            pin9_oe_r <= p9_if.oe;
            gp_out_r <= gp_drive;
            gp_oe_r <= gp_en;
            pin9_in_r <= pin9_in;
            gp_in_r <= gp_in;
        end
    end

    // ==========================================
    // outputs
    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign fwd_valid = fwd_valid_r;
    assign fwd_addr = fwd_addr_r;
    assign pin9_out = pin9_out_r;
    assign pin9_oe = pin9_oe_r;
    assign gp_out = gp_out_r;
    assign gp_oe = gp_oe_r;

endmodule

`default_nettype wire

// file: hdl/lamcfg_pad.sv
// holds no logic of its own
// assumes: nothing
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

// file: bench/lamcfg_monitor.sv
// checker for the alias, mailbox and pin bank
// assumes: bound to lamcfg_bank, single pclk domain
`timescale 1ns/10ps
`default_nettype none
`include "lamcfg_regs.svh"

module lamcfg_monitor
#(
    parameter int NUM_GP = 3
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic i2c_addr_valid,
    input wire logic [6:0] i2c_addr,
    input wire logic fwd_valid,
    input wire logic [6:0] fwd_addr,
    input wire logic pin9_remote_level,
    input wire logic pin9_func_out,
    input wire logic pin9_out,
    input wire logic pin9_oe,
    input wire logic [2*NUM_GP-1:0] gp_cfg,
    input wire logic [NUM_GP-1:0] gp_level,
    input wire logic [NUM_GP-1:0] gp_func_out,
    input wire logic [NUM_GP-1:0] gp_out,
    input wire logic [NUM_GP-1:0] gp_oe
);
    // ====================
    // shadow of writable registers
    logic [7:0] sh_r [256];
    logic [7:0] idx;
    logic [7:0] pc;
    logic rw;
    logic ok;
    logic hit;
    logic [1:0] e9;
    logic [NUM_GP-1:0] eg_oe;
    logic [NUM_GP-1:0] eg_out;

    function automatic logic [7:0] msk(input logic [7:0] i);
        case (i)
            `LAMCFG_IDX_ALIAS7, `LAMCFG_IDX_TGTID7: msk = `LAMCFG_ALIAS_MASK;
            `LAMCFG_IDX_PINCFG: msk = `LAMCFG_PINCFG_MASK;
            `LAMCFG_IDX_RMTCTL: msk = `LAMCFG_RMTCTL_MASK;
            default: msk = 8'hff;
        endcase
    endfunction

    // {oe, oe and level}
    function automatic logic [1:0] pe(input logic [1:0] c, input logic [7:0] g,
        input logic lv, input logic re, input logic rl, input logic fo);
        casez ({c, g[5:4]})
            4'b01??: pe = {1'b1, re ? rl : lv};
            4'b0000: pe = {1'b1, fo};
            4'b0001: pe = {1'b1, g[7]};
            default: pe = 2'b00;
        endcase
    endfunction

    assign idx = paddr[9:2];
    assign pc = sh_r[`LAMCFG_IDX_PINCFG];
    assign ok = paddr[11:10] == 2'b00 && paddr[1:0] == 2'b00;
    assign rw = idx inside {[`LAMCFG_IDX_ALIAS7:`LAMCFG_IDX_PINCFG],
        `LAMCFG_IDX_TGTID7, `LAMCFG_IDX_RMTCTL};
    assign hit = i2c_addr_valid && sh_r[`LAMCFG_IDX_ALIAS7][7:1] != 7'h00
        && i2c_addr == sh_r[`LAMCFG_IDX_ALIAS7][7:1];
    assign e9 = pe(pc[1:0], pc, pc[3], sh_r[`LAMCFG_IDX_RMTCTL][0],
        pin9_remote_level, pin9_func_out);

    always_comb
    begin
        for (int i = 0; i < NUM_GP; i++)
        begin
            {eg_oe[i], eg_out[i]} = pe(gp_cfg[2*i+:2], pc, gp_level[i], 1'b0, 1'b0,
                gp_func_out[i]);
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int i = 0; i < 256; i++)
            begin
                sh_r[i] <= 8'h00;
            end
            sh_r[`LAMCFG_IDX_MSG_B] <= `LAMCFG_RST_MSG_B;
        end
        else if (psel && penable && pready && pwrite && !pslverr && pstrb[0] && rw && ok)
        begin
            sh_r[idx] <= pwdata[7:0] & msk(idx);
        end
    end

    // ====================
    // properties
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_fwd;
        fwd_valid && fwd_addr == $past(sh_r[`LAMCFG_IDX_TGTID7][7:1]);
    endsequence

    setup_ready_a: assert property (s_setup |=> pready)
        else $error("no ready after setup");
    ready_single_a: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    bad_addr_a: assert property (pready && !(ok && (rw || idx == `LAMCFG_IDX_STATUS))
        |-> pslverr && (pwrite || prdata == 32'h0000_0000))
        else $error("bad address not refused");
    reg_read_a: assert property (pready && !pwrite && rw && ok
        |-> !pslverr && prdata == {24'h00_0000, sh_r[idx]})
        else $error("read data differs from written value");
    alias_fwd_a: assert property (hit |=> s_fwd)
        else $error("alias match not forwarded");
    alias_quiet_a: assert property (fwd_valid |-> $past(hit))
        else $error("forward without alias match");
    fwd_hold_a: assert property (!fwd_valid |-> $stable(fwd_addr))
        else $error("forward address moved");
    pin9_drive_a: assert property ($past(presetn)
        |-> {pin9_oe, pin9_oe & pin9_out} == $past(e9))
        else $error("pin9 drive wrong");
    gp_drive_a: assert property ($past(presetn)
        |-> gp_oe == $past(eg_oe) && (gp_out & gp_oe) == $past(eg_out))
        else $error("shared pin drive wrong");
endmodule

bind lamcfg_bank lamcfg_monitor #(.NUM_GP(NUM_GP)) u_mon (.*);

`default_nettype wire

// file: bench/lamcfg_far.sv
// far side: i2c address source, remote levels, pin wires
// assumes: tasks called right after a pclk rising edge
`timescale 1ns/10ps
`default_nettype none

module lamcfg_far
#(
    parameter int NUM_GP = 3
)
(
    input wire logic pclk,
    input wire logic fwd_valid,
    input wire logic pin9_out,
    input wire logic pin9_oe,
    input wire logic [NUM_GP-1:0] gp_out,
    input wire logic [NUM_GP-1:0] gp_oe,
    output logic i2c_addr_valid,
    output logic [6:0] i2c_addr,
    output logic pin9_func_out,
    output logic pin9_remote_level,
    output logic [NUM_GP-1:0] gp_func_out,
    output logic pin9_in,
    output logic [NUM_GP-1:0] gp_in
);
    logic ld9_r = 1'b0;
    logic [NUM_GP-1:0] ldg_r = '0;

    initial
    begin
        i2c_addr_valid = 1'b0;
        i2c_addr = 7'h00;
        pin9_func_out = 1'b0;
        pin9_remote_level = 1'b0;
        gp_func_out = '0;
    end

    // undriven wire shows the inverse of its last level
    always @(posedge pclk)
    begin
        ld9_r <= pin9_oe ? pin9_out : ld9_r;
        ldg_r <= (gp_oe & gp_out) | (~gp_oe & ldg_r);
    end
    assign pin9_in = pin9_oe ? pin9_out : ~ld9_r;
    assign gp_in = (gp_oe & gp_out) | (~gp_oe & ~ldg_r);

    task automatic strobe(input logic [6:0] a, output logic hit);
        i2c_addr_valid <= 1'b1;
        i2c_addr <= a;
        @(posedge pclk);
        i2c_addr_valid <= 1'b0;
        i2c_addr <= ~a;
        @(posedge pclk);
        hit = fwd_valid;
    endtask

    task automatic levels(input logic [NUM_GP+1:0] v);
        pin9_func_out <= v[0];
        pin9_remote_level <= v[1];
        gp_func_out <= v[NUM_GP+1:2];
    endtask
endmodule

`default_nettype wire

// file: bench/test_lamcfg_bank.sv
// self-checking bench for the alias, mailbox and pin bank
// assumes: bank answers apb with its own pready; far side model present
`timescale 1ns/10ps
`default_nettype none
`include "lamcfg_regs.svh"

module test_lamcfg_bank;
    localparam int NG = 3;
    localparam logic [7:0] IX [6] = '{`LAMCFG_IDX_ALIAS7, `LAMCFG_IDX_MSG_A,
        `LAMCFG_IDX_MSG_B, `LAMCFG_IDX_PINCFG, `LAMCFG_IDX_TGTID7, `LAMCFG_IDX_RMTCTL};
    localparam logic [7:0] RV [6] = '{`LAMCFG_RST_ALIAS7, `LAMCFG_RST_MSG_A,
        `LAMCFG_RST_MSG_B, `LAMCFG_RST_PINCFG, `LAMCFG_RST_TGTID7, `LAMCFG_RST_RMTCTL};
    localparam logic [7:0] MK [6] = '{8'hfe, 8'hff, 8'hff, 8'hbb, 8'hfe, 8'h01};
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [3:0] pstrb = 4'hf;
    logic [2*NG-1:0] gp_cfg = '0;
    logic [NG-1:0] gp_level = '0;
    logic [31:0] prdata;
    logic pready, pslverr, fwd_valid, pin9_out, pin9_oe, pin9_in;
    logic i2c_addr_valid, pin9_func_out, pin9_remote_level, h;
    logic [6:0] i2c_addr, fwd_addr;
    logic [NG-1:0] gp_out, gp_oe, gp_in, gp_func_out;
    logic [5:0] v;
    logic [7:0] c8;
    int errors = 0;
    int checked = 0;
    int cyc = 0;

    lamcfg_bank #(.NUM_GP(NG)) u_dut (.*);
    lamcfg_far #(.NUM_GP(NG)) u_far (.*);

    always #2.5 pclk = ~pclk;

    task automatic finish_test();
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            errors++;
            finish_test();
        end
    end

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        checked++;
        if (s !== e)
        begin
            errors++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask

    // one apb transfer, then one idle cycle
    task automatic apb(input logic w, input logic [7:0] i, input logic [1:0] lo,
        input logic [7:0] d, input logic [3:0] s, input logic [31:0] e, input logic ee);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'b00, i, lo};
        pwdata <= {~d, ~d, ~d, d};
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1);
        chk("pready wait", 32'd1, 32'(n));
        chk("pslverr", 32'(ee), 32'(pslverr));
        if (!w)
            chk("prdata", e, prdata);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [7:0] i, input logic [7:0] d);
        apb(1'b1, i, 2'b00, d, 4'hf, 8'h00, 1'b0);
    endtask

    task automatic rd(input logic [7:0] i, input logic [7:0] e);
        apb(1'b0, i, 2'b00, 8'h00, 4'hf, 32'(e), 1'b0);
    endtask

    function automatic logic [1:0] ex(input logic [1:0] c, input logic [7:0] g,
        input logic lv, input logic re, input logic rl, input logic fo);
        if (c == 2'b01)
            return {1'b1, re ? rl : lv};
        if (c != 2'b00 || g[5])
            return 2'b00;
        return {1'b1, g[4] ? g[7] : fo};
    endfunction

    initial
    begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        foreach (IX[k])
            rd(IX[k], RV[k]);
        $display("test reset values done");
        foreach (IX[k])
        begin
            wr(IX[k], 8'hff);
            apb(1'b1, IX[k], 2'b00, 8'h24, 4'he, 8'h00, 1'b0);
            rd(IX[k], MK[k]);
        end
        wr(`LAMCFG_IDX_MSG_A, 8'ha5);
        wr(`LAMCFG_IDX_MSG_B, 8'h5a);
        apb(1'b0, 8'h30, 2'b00, 8'h00, 4'hf, 8'h00, 1'b1);
        apb(1'b1, `LAMCFG_IDX_MSG_A, 2'b10, 8'h11, 4'hf, 8'h00, 1'b1);
        apb(1'b1, `LAMCFG_IDX_STATUS, 2'b00, 8'h11, 4'hf, 8'h00, 1'b1);
        rd(`LAMCFG_IDX_MSG_A, 8'ha5);
        rd(`LAMCFG_IDX_MSG_B, 8'h5a);
        $display("test mailbox and refusals done");
        wr(`LAMCFG_IDX_TGTID7, 8'h84);
        wr(`LAMCFG_IDX_ALIAS7, 8'h00);
        u_far.strobe(7'h00, h);
        chk("fwd off", 32'(1'b0), 32'(h));
        wr(`LAMCFG_IDX_ALIAS7, 8'h35);
        u_far.strobe(7'h1a, h);
        chk("fwd hit", 32'(1'b1), 32'(h));
        chk("fwd_addr", 32'(7'h42), 32'(fwd_addr));
        u_far.strobe(7'h1b, h);
        chk("fwd miss", 32'(1'b0), 32'(h));
        chk("fwd_addr held", 32'(7'h42), 32'(fwd_addr));
        apb(1'b0, `LAMCFG_IDX_STATUS, 2'b00, 8'h00, 4'hf, 32'h0007_0101, 1'b0);
        $display("test alias done");
        for (int m = 0; m < 64; m++)
        begin
            v = 6'(m);
            c8 = {~v[4], 1'b0, v[3:2], v[4], 1'b0, v[1:0]};
            wr(`LAMCFG_IDX_PINCFG, c8);
            wr(`LAMCFG_IDX_RMTCTL, {7'h00, v[5]});
            u_far.levels({v[2:0] ^ 3'h3, v[1] ^ v[2], v[0]});
            gp_cfg <= {v[1:0], ~v[1:0], 2'b00};
            gp_level <= v[2:0] ^ 3'h5;
            repeat (2) @(posedge pclk);
            chk("pin9", 32'(ex(c8[1:0], c8, c8[3], v[5], pin9_remote_level, pin9_func_out)),
                32'({pin9_oe, pin9_oe & pin9_out}));
            for (int j = 0; j < NG; j++)
                chk("gp pin", 32'(ex(gp_cfg[2*j+:2], c8, gp_level[j], 1'b0, 1'b0,
                    gp_func_out[j])), 32'({gp_oe[j], gp_oe[j] & gp_out[j]}));
        end
        $display("test pin modes done");
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd(`LAMCFG_IDX_MSG_B, `LAMCFG_RST_MSG_B);
        $display("test second reset done");
        finish_test();
    end
endmodule

`default_nettype wire
